// ---- verilog/adcc_pkg.sv ----
package adcc_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADDR_MUX_SEL  = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_INT_EN   = 8'h10;
	localparam logic [7:0] ADDR_INT_CLR  = 8'h14;
	localparam logic [7:0] ADDR_RESULT   = 8'h18;

	// control one field positions
	localparam int BIT_CONVERTER_ON  = 15;
	localparam int BIT_STOP_IN_IDLE  = 13;
	localparam int BIT_DMA_ORDER     = 12;
	localparam int BIT_RESOLUTION    = 10;
	localparam int BIT_FORMAT_LO     = 8;
	localparam int BIT_AUTO_SAMPLE   = 2;
	localparam int BIT_SAMPLE_CTRL   = 1;
	localparam int BIT_CONV_DONE     = 0;
	// control two field positions
	localparam int BIT_BUFFER_FILL   = 1;
	localparam int BIT_ALT_SELECT    = 0;
	// mux select field positions
	localparam int BIT_MUX_FIRST_LO  = 0;
	localparam int BIT_MUX_SECOND_LO = 8;
	// status, enable and clear layout
	localparam int EVT_DONE          = 0;
	localparam int EVT_BUFFER        = 1;
	localparam int EVT_COUNT         = 2;

	// writable masks and reset values
	localparam logic [15:0] CTRL_ONE_MASK = 16'hB706;
	localparam logic [15:0] CTRL_ONE_RST  = 16'h0000;
	localparam logic [1:0]  CTRL_TWO_RST  = 2'h0;
	localparam logic [4:0]  MUX_SEL_RST   = 5'h00;

	// output format codes
	localparam logic [1:0] FMT_INTEGER   = 2'h0;
	localparam logic [1:0] FMT_SIGNED    = 2'h1;
	localparam logic [1:0] FMT_FRACTION  = 2'h2;
	localparam logic [1:0] FMT_SFRACTION = 2'h3;

	// dma buffer geometry, in result words
	localparam int BUF_HALF_WORDS = 8;
	localparam int SG_WORDS       = 4;
	localparam int CHAN_COUNT     = 4;
	localparam logic [3:0] HALF_LAST = 4'h7;
	localparam logic [1:0] SG_LAST   = 2'h3;

	// automatic sample time
	localparam int  CLK_MHZ         = 200;
	localparam int  SAMPLE_TIME_NS  = 20;
	localparam int  SAMPLE_CYCLES   = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);

	typedef enum logic [3:0] {
		ST_STOP   = 4'h1,
		ST_WAIT   = 4'h2,
		ST_SAMPLE = 4'h4,
		ST_CONV   = 4'h8
	} adcc_state_t;
endpackage

// ---- verilog/adcc_format.sv ----
`timescale 1ns/1ps
// result formatter: raw conversion code to the 16-bit output word
module adcc_format
	import adcc_pkg::*;
(
	input  wire logic        res12_in,
	input  wire logic [1:0]  format_in,
	input  wire logic [11:0] raw_in,
	output logic      [15:0] word_out
);
	logic [9:0]  d10;
	logic [11:0] d12;

	assign d10 = raw_in[9:0];
	assign d12 = raw_in;

	// sign bit is the inverse of the result msb in the signed codes
	always_comb begin
		word_out = 16'h0000;
		if (res12_in) begin
			unique case (format_in)
				FMT_INTEGER:   word_out = {4'h0, d12}; // R6
				FMT_SIGNED:    word_out = {{5{~d12[11]}}, d12[10:0]};
				FMT_FRACTION:  word_out = {d12, 4'h0}; // R6
				FMT_SFRACTION: word_out = {~d12[11], d12[10:0], 4'h0}; // R6
			endcase
		end else begin
			unique case (format_in)
				FMT_INTEGER:   word_out = {6'h00, d10}; // R5
				FMT_SIGNED:    word_out = {{7{~d10[9]}}, d10[8:0]};
				FMT_FRACTION:  word_out = {d10, 6'h00};
				FMT_SFRACTION: word_out = {~d10[9], d10[8:0], 6'h00}; // R5
			endcase
		end
	end
endmodule

// ---- verilog/adcc_top.sv ----
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
//
// Behaviour
// R1 - enable bit runs converter, clear turns off
// R2 - stop-in-idle halts converter during idle
// R3 - dma order or scatter/gather addresses
// R4 - resolution bit: 12-bit one-channel or 10-bit
// R5 - 10-bit integer and signed fractional formats
// R6 - 12-bit signed fraction, fraction, integer formats
// R7 - software keeps done while auto sampling
// R8 - fill mode alternates halves, else restarts
// R9 - alternate bit toggles mux first, second
// R10 - hardware sets done, drives sample control
//
module adcc_top
	import adcc_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        idle_in,
	input  wire logic        conv_done_in,
	input  wire logic [11:0] conv_data_in,
	input  wire logic [1:0]  conv_chan_in,
	output logic             active_out,
	output logic             res12_out,
	output logic             sample_out,
	output logic             conv_start_out,
	output logic [4:0]       chan_sel_out,
	output logic             mux_second_out,
	output logic             dma_req_out,
	output logic [15:0]      dma_data_out,
	output logic [4:0]       dma_addr_out,
	output logic             irq_out
);
	logic [15:0]          ctrl_one;
	logic [1:0]           ctrl_two;
	logic [4:0]           input_mux_first;
	logic [4:0]           input_mux_second;
	logic [EVT_COUNT-1:0] status;
	logic [EVT_COUNT-1:0] int_en;
	logic [15:0]          result;
	logic                 conv_done_flag;
	adcc_state_t          state;
	adcc_state_t          next_state;
	logic [3:0]           sample_cnt;
	logic [3:0]           fill_cnt;
	logic                 fill_half;
	logic [1:0]           sg_cnt [CHAN_COUNT];
	logic [15:0]          fmt_word;
	logic                 wr_en;
	logic                 rd_setup;
	logic                 converter_on;
	logic                 running;
	logic                 auto_sample_enable;
	logic                 done_evt;
	logic                 buf_evt;
	logic [1:0]           chan_idx;
	logic [EVT_COUNT-1:0] evt_vec;
	logic [EVT_COUNT-1:0] clr_vec;

	// address decode shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_CTRL_ONE) || (a == ADDR_CTRL_TWO) || (a == ADDR_MUX_SEL) ||
			(a == ADDR_STATUS) || (a == ADDR_INT_EN) || (a == ADDR_INT_CLR) ||
			(a == ADDR_RESULT);
	endfunction

	assign wr_en = ce_in && psel_in && penable_in && pready_out && pwrite_in;
	assign rd_setup = psel_in && !penable_in;
	assign converter_on = ctrl_one[BIT_CONVERTER_ON];
	assign auto_sample_enable = ctrl_one[BIT_AUTO_SAMPLE];
	assign running = converter_on && !(ctrl_one[BIT_STOP_IN_IDLE] && idle_in); // R1 R2
	assign done_evt = (state == ST_CONV) && conv_done_in;
	assign chan_idx = ctrl_one[BIT_RESOLUTION] ? 2'h0 : conv_chan_in; // R4
	assign buf_evt = done_evt && (fill_cnt == HALF_LAST);
	assign evt_vec = {buf_evt, done_evt};
	assign clr_vec = (wr_en && paddr_in == ADDR_INT_CLR) ? pwdata_in[EVT_COUNT-1:0] : '0;

	adcc_format u_format (
		.res12_in  (ctrl_one[BIT_RESOLUTION]),
		.format_in (ctrl_one[BIT_FORMAT_LO +: 2]),
		.raw_in    (conv_data_in),
		.word_out  (fmt_word)
	);

	// apb slave: zero wait state, answer in the first access cycle
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			pready_out <= rd_setup;
			pslverr_out <= rd_setup && !mapped(paddr_in);
			if (rd_setup) begin
				unique case (paddr_in)
					ADDR_CTRL_ONE: prdata_out <= {16'h0000, ctrl_one[15:1], conv_done_flag};
					ADDR_CTRL_TWO: prdata_out <= {30'h0, ctrl_two};
					ADDR_MUX_SEL:  prdata_out <= {19'h0, input_mux_second, 3'h0, input_mux_first};
					ADDR_STATUS:   prdata_out <= {30'h0, status};
					ADDR_INT_EN:   prdata_out <= {30'h0, int_en};
					ADDR_RESULT:   prdata_out <= {16'h0000, result};
					default:       prdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control one: software fields; sample bit follows the state machine
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_one <= CTRL_ONE_RST;
		end else if (ce_in) begin
			if (wr_en && paddr_in == ADDR_CTRL_ONE)
				ctrl_one <= pwdata_in[15:0] & CTRL_ONE_MASK;
			ctrl_one[BIT_SAMPLE_CTRL] <= (next_state == ST_SAMPLE); // R10
		end
	end

	// conversion-complete flag: hardware set wins over software clear
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			conv_done_flag <= 1'b0;
		end else if (ce_in) begin
			if (done_evt)
				conv_done_flag <= 1'b1; // R10
			else if (wr_en && paddr_in == ADDR_CTRL_ONE && !pwdata_in[BIT_CONV_DONE])
				conv_done_flag <= 1'b0; // R10
		end
	end

	// control two and mux selects
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_two <= CTRL_TWO_RST;
			input_mux_first <= MUX_SEL_RST;
			input_mux_second <= MUX_SEL_RST;
			int_en <= '0;
		end else if (ce_in && wr_en) begin
			if (paddr_in == ADDR_CTRL_TWO)
				ctrl_two <= pwdata_in[1:0];
			if (paddr_in == ADDR_MUX_SEL) begin
				input_mux_first <= pwdata_in[BIT_MUX_FIRST_LO +: 5];
				input_mux_second <= pwdata_in[BIT_MUX_SECOND_LO +: 5];
			end
			if (paddr_in == ADDR_INT_EN)
				int_en <= pwdata_in[EVT_COUNT-1:0];
		end
	end

	// sticky event bits, set wins over write-one clear
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status <= '0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			status <= (status & ~clr_vec) | evt_vec;
			irq_out <= |(((status & ~clr_vec) | evt_vec) & int_en);
		end
	end

	// sample and convert sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			ST_STOP:
				if (running)
					next_state = ST_WAIT;
			ST_WAIT:
				if (auto_sample_enable || (wr_en && paddr_in == ADDR_CTRL_ONE &&
					pwdata_in[BIT_SAMPLE_CTRL]))
					next_state = ST_SAMPLE;
			ST_SAMPLE:
				if (auto_sample_enable ? (sample_cnt == SAMPLE_LAST) :
					(wr_en && paddr_in == ADDR_CTRL_ONE && !pwdata_in[BIT_SAMPLE_CTRL]))
					next_state = ST_CONV;
			ST_CONV:
				if (conv_done_in)
					next_state = auto_sample_enable ? ST_SAMPLE : ST_WAIT; // R10
		endcase
		if (!running)
			next_state = ST_STOP; // R1 R2
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ST_STOP;
			sample_cnt <= 4'h0;
			conv_start_out <= 1'b0;
		end else if (ce_in) begin
			state <= next_state;
			conv_start_out <= (state == ST_SAMPLE) && (next_state == ST_CONV);
			sample_cnt <= (state == ST_SAMPLE) ? 4'(sample_cnt + 4'h1) : 4'h0;
		end
	end

	// buffer fill position, restarted or alternated per half
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fill_cnt <= 4'h0;
			fill_half <= 1'b0;
		end else if (ce_in) begin
			if (!converter_on) begin
				fill_cnt <= 4'h0;
				fill_half <= 1'b0;
			end else if (done_evt) begin
				fill_cnt <= buf_evt ? 4'h0 : 4'(fill_cnt + 4'h1);
				if (buf_evt)
					fill_half <= ctrl_two[BIT_BUFFER_FILL] ? ~fill_half : 1'b0; // R8
			end
		end
	end

	// one scatter/gather slot counter per analog input
	genvar gi;
	generate
		for (gi = 0; gi < CHAN_COUNT; gi++) begin : g_sg
			always_ff @(posedge clk_sys_in or negedge rstn_in) begin
				if (!rstn_in)
					sg_cnt[gi] <= 2'h0;
				else if (ce_in) begin
					if (!converter_on)
						sg_cnt[gi] <= 2'h0;
					else if (done_evt && chan_idx == 2'(gi))
						sg_cnt[gi] <= 2'(sg_cnt[gi] + 2'h1);
				end
			end
		end
	endgenerate

	// dma word and address on each finished conversion
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dma_req_out <= 1'b0;
			dma_data_out <= 16'h0000;
			dma_addr_out <= 5'h00;
			result <= 16'h0000;
		end else if (ce_in) begin
			dma_req_out <= done_evt;
			if (done_evt) begin
				dma_data_out <= fmt_word; // R5 R6
				result <= fmt_word;
				if (ctrl_one[BIT_DMA_ORDER])
					dma_addr_out <= 5'(fill_cnt) + (fill_half ? 5'(BUF_HALF_WORDS) : 5'h00); // R3 R8
				else
					dma_addr_out <= {1'b0, chan_idx, sg_cnt[chan_idx]}; // R3
			end
		end
	end

	// input select alternation between the two multiplexers
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mux_second_out <= 1'b0;
			chan_sel_out <= 5'h00;
		end else if (ce_in) begin
			if (!ctrl_two[BIT_ALT_SELECT] || !converter_on) begin
				mux_second_out <= 1'b0; // R9
				chan_sel_out <= input_mux_first;
			end else begin
				if (done_evt)
					mux_second_out <= ~mux_second_out; // R9
				chan_sel_out <= (done_evt ^ mux_second_out) ? input_mux_second :
					input_mux_first;
			end
		end
	end

	// status pins toward the analog core
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			active_out <= 1'b0;
			res12_out <= 1'b0;
			sample_out <= 1'b0;
		end else if (ce_in) begin
			active_out <= running; // R1 R2
			res12_out <= ctrl_one[BIT_RESOLUTION]; // R4
			sample_out <= (next_state == ST_SAMPLE);
		end
	end

	sequence s_sample_full;
		(state == ST_SAMPLE && auto_sample_enable && running && sample_cnt == SAMPLE_LAST);
	endsequence

	sequence s_conv_begins;
		##1 (state == ST_CONV && conv_start_out);
	endsequence

	a_active_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R1
		ce_in |=> (active_out == $past(running)))
		else $error("active pin does not follow enable and idle");
	a_idle_stop: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R2
		(ce_in && ctrl_one[BIT_STOP_IN_IDLE] && idle_in) |=> (state == ST_STOP))
		else $error("converter kept running in idle");
	a_order_addr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R3
		(ce_in && done_evt && ctrl_one[BIT_DMA_ORDER])
		|=> dma_req_out && dma_addr_out == {1'b0, $past(fill_half), $past(fill_cnt[2:0])})
		else $error("dma address not in conversion order");
	a_sg_region: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R3
		(ce_in && done_evt && !ctrl_one[BIT_DMA_ORDER])
		|=> dma_addr_out[3:2] == $past(chan_idx))
		else $error("scatter address outside input region");
	a_res_pin: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R4
		(ce_in && ctrl_one[BIT_RESOLUTION] && done_evt) |=> dma_addr_out[3:2] == 2'h0 ||
		$past(ctrl_one[BIT_DMA_ORDER]))
		else $error("12-bit mode used a channel other than zero");
	a_fmt_ten: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R5
		(ce_in && done_evt && !ctrl_one[BIT_RESOLUTION] &&
		ctrl_one[BIT_FORMAT_LO +: 2] == FMT_SFRACTION)
		|=> dma_data_out[5:0] == 6'h00 && dma_data_out[15] == !$past(conv_data_in[9]))
		else $error("10-bit signed fraction misformatted");
	a_fmt_twelve: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R6
		(ce_in && done_evt && ctrl_one[BIT_RESOLUTION] &&
		ctrl_one[BIT_FORMAT_LO +: 2] == FMT_INTEGER)
		|=> dma_data_out == {4'h0, $past(conv_data_in)})
		else $error("12-bit integer misformatted");
	a_fill_restart: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R8
		(ce_in && buf_evt && !ctrl_two[BIT_BUFFER_FILL]) |=> !fill_half && fill_cnt == 4'h0)
		else $error("fill did not restart at start address");
	a_alt_toggle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R9
		(ce_in && done_evt && ctrl_two[BIT_ALT_SELECT] && converter_on)
		|=> mux_second_out != $past(mux_second_out))
		else $error("multiplexer did not alternate");
	a_done_set: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R10
		(ce_in && done_evt) |=> conv_done_flag)
		else $error("done flag not set by finished conversion");
	a_auto_start: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R10
		(s_sample_full and ce_in) |-> s_conv_begins)
		else $error("auto sample did not start a conversion");
endmodule

// ---- test/adcc_far_end.sv ----
`timescale 1ns/1ps
// analog core stand-in: answers each conversion start after a set delay
module adcc_far_end (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        conv_start_in,
	input  wire logic [3:0]  delay_in,
	input  wire logic [11:0] raw_in,
	input  wire logic [1:0]  chan_in,
	output logic             conv_done_out,
	output logic [11:0]      conv_data_out,
	output logic [1:0]       conv_chan_out
);
	logic        done_q = 1'b0;
	logic [11:0] data_q = 12'h000;
	logic [1:0]  chan_q = 2'h0;
	logic        busy   = 1'b0;
	logic [3:0]  count  = 4'h0;

	// outputs follow the internal state
	assign conv_done_out = done_q;
	assign conv_data_out = data_q;
	assign conv_chan_out = chan_q;

	// data lines toggle outside a result so a stale value never matches
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			done_q <= 1'b0;
			busy   <= 1'b0;
			count  <= 4'h0;
		end else begin
			done_q <= 1'b0;
			data_q <= ~data_q;
			chan_q <= ~chan_q;
			if (conv_start_in) begin
				busy  <= 1'b1;
				count <= delay_in;
			end else if (busy && count != 4'h0) begin
				count <= count - 4'h1;
			end else if (busy) begin
				busy   <= 1'b0;
				done_q <= 1'b1;
				data_q <= raw_in;
				chan_q <= chan_in;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb import adcc_pkg::*;;
	typedef struct packed {
		logic        res;
		logic [1:0]  fmt;
		logic [11:0] raw;
		logic [15:0] exp;
	} adcc_row_t;

	logic        clk_sys_in = 1'b0;
	logic        rstn_in    = 1'b0;
	logic        ce_in      = 1'b1;
	logic        psel_in    = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in  = 1'b0;
	logic        idle_in    = 1'b0;
	logic [7:0]  paddr_in   = 8'h00;
	logic [31:0] pwdata_in  = 32'h0;
	logic [11:0] raw        = 12'h000;
	logic [1:0]  chan       = 2'h0;
	logic [3:0]  delay      = 4'h0;
	logic [31:0] prdata_out, rd;
	logic        pready_out, pslverr_out, err, conv_done_in, active_out, res12_out;
	logic        sample_out, conv_start_out, mux_second_out, dma_req_out, irq_out;
	logic [11:0] conv_data_in;
	logic [1:0]  conv_chan_in;
	logic [4:0]  chan_sel_out, dma_addr_out;
	logic [15:0] dma_data_out;
	int          fails        = 0;
	int          total_checks = 0;
	adcc_row_t   rows [8] = '{
		{1'b0, 2'h0, 12'hEA5, 16'h02A5}, {1'b0, 2'h3, 12'h2A5, 16'h2940},
		{1'b0, 2'h3, 12'h15A, 16'hD680}, {1'b0, 2'h2, 12'h2A5, 16'hA940},
		{1'b1, 2'h3, 12'hABC, 16'h2BC0}, {1'b1, 2'h2, 12'hABC, 16'hABC0},
		{1'b1, 2'h0, 12'hABC, 16'h0ABC}, {1'b1, 2'h3, 12'h123, 16'h9230}};

	adcc_top dut (
		.clk_sys_in, .rstn_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .idle_in, .conv_done_in,
		.conv_data_in, .conv_chan_in, .active_out, .res12_out, .sample_out,
		.conv_start_out, .chan_sel_out, .mux_second_out, .dma_req_out, .dma_data_out,
		.dma_addr_out, .irq_out
	);

	adcc_far_end far (
		.clk_sys_in, .rstn_in, .conv_start_in(conv_start_out), .delay_in(delay),
		.raw_in(raw), .chan_in(chan), .conv_done_out(conv_done_in),
		.conv_data_out(conv_data_in), .conv_chan_out(conv_chan_in)
	);

	// 200 MHz system clock
	always #2.5 clk_sys_in = ~clk_sys_in;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do @(posedge clk_sys_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask

	// auto sampling goes off first, done is cleared only afterwards
	task stop();
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_8001);
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0000);
	endtask

	task end_sim();
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		fails++;
		end_sim();
	end

	// main sequence: reset, format rows, buffer modes, idle, bad accesses
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		apb(1'b0, ADDR_CTRL_ONE, 32'h0);
		chk("ctrl_one reset", 32'h0, rd);
		for (int i = 0; i < 8; i++) begin
			raw <= rows[i].raw;
			apb(1'b1, ADDR_INT_EN, {31'h0, i[0]});
			apb(1'b1, ADDR_CTRL_ONE, 32'h8004 | {rows[i].res, 10'h0} | {rows[i].fmt, 8'h0});
			do @(posedge clk_sys_in); while (dma_req_out !== 1'b1);
			chk("dma_data", rows[i].exp, dma_data_out);
			chk("res12", rows[i].res, res12_out);
			apb(1'b0, ADDR_CTRL_ONE, 32'h0);
			chk("done flag", 32'h1, rd[0]);
			stop();
			chk("irq", i[0], irq_out);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("done event", 32'h1, rd[0]);
			apb(1'b1, ADDR_INT_CLR, 32'h3);
			repeat (2) @(posedge clk_sys_in);
			chk("irq cleared", 32'h0, irq_out);
		end
		apb(1'b1, ADDR_MUX_SEL, 32'h0000_1C03);
		chan <= 2'h2;
		for (int m = 0; m < 3; m++) begin
			delay <= 4'(m * 3);
			apb(1'b1, ADDR_CTRL_TWO, (m == 0) ? 32'h3 : 32'h0);
			apb(1'b1, ADDR_CTRL_ONE, (m == 2) ? 32'h8004 : 32'h9404);
			for (int i = 0; i < 16; i++) begin
				do @(posedge clk_sys_in); while (conv_start_out !== 1'b1);
				chk("chan_sel", (m == 0 && i[0]) ? 5'h1C : 5'h03, chan_sel_out);
				chk("mux_second", m == 0 && i[0], mux_second_out);
				do @(posedge clk_sys_in); while (dma_req_out !== 1'b1);
				chk("dma_addr", (m == 0) ? i : (m == 1) ? i % 8 : 8 + i % 4, dma_addr_out);
			end
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (m < 2) chk("half event", 32'h1, rd[1]);
			stop();
			apb(1'b1, ADDR_INT_CLR, 32'h3);
		end
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_A000);
		idle_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		chk("active idle stop", 32'h0, active_out);
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_8000);
		repeat (2) @(posedge clk_sys_in);
		chk("active idle run", 32'h1, active_out);
		// manual sampling: software raises the sample bit, lowering it starts a conversion
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_8002);
		apb(1'b0, ADDR_CTRL_ONE, 32'h0);
		chk("manual sample bit", 32'h8002, rd);
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_8000);
		do @(posedge clk_sys_in); while (dma_req_out !== 1'b1);
		chk("manual dma_data", 32'h0123, dma_data_out);
		apb(1'b0, ADDR_CTRL_ONE, 32'h0);
		chk("manual done", 32'h8001, rd);
		idle_in <= 1'b0;
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_4800);
		repeat (2) @(posedge clk_sys_in);
		chk("active off", 32'h0, active_out);
		apb(1'b0, ADDR_CTRL_ONE, 32'h0);
		chk("ctrl_one reserved", 32'h0, rd);
		apb(1'b1, ADDR_CTRL_TWO, 32'hFFFF_FFFF);
		apb(1'b0, ADDR_CTRL_TWO, 32'h0);
		chk("ctrl_two bits", 32'h3, rd);
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		chk("unmapped write err", 32'h1, err);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped read err", 32'h1, err);
		// clock enable low freezes sampling part way through
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_8004);
		do @(posedge clk_sys_in); while (sample_out !== 1'b1);
		ce_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		chk("frozen sample", 32'h1, sample_out);
		chk("frozen start", 32'h0, conv_start_out);
		ce_in <= 1'b1;
		do @(posedge clk_sys_in); while (conv_start_out !== 1'b1);
		// reset in mid-run clears outputs and registers
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		chk("reset active", 32'h0, active_out);
		chk("reset start", 32'h0, conv_start_out);
		rstn_in <= 1'b1;
		apb(1'b0, ADDR_CTRL_ONE, 32'h0);
		chk("ctrl_one after reset", 32'h0, rd);
		end_sim();
	end
endmodule
